// File: rtl/vtiming_params.svh
// Purpose: Register indices, field positions and reset values for the vertical timing block
// Assumes: Registers are reached by index and data strobes, with no other bus
// Notes:
`ifndef VTIMING_PARAMS_SVH
`define VTIMING_PARAMS_SVH
`define IDX_VSE 8'h11
`define IDX_VDE 8'h12
`define IDX_ROFF 8'h13
`define IDX_UL 8'h14
`define IDX_VBS 8'h15
`define IDX_VBE 8'h16
`define IDX_MODE 8'h17
`define VSE_PROT 7
`define VSE_IEN_N 5
`define VSE_ICLR_N 4
`define UL_DWORD 6
`define UL_BY4 5
`define MD_HOLD_N 7
`define MD_BYTE 6
`define MD_ALT0 5
`define MD_LIN2 3
`define MD_LINE2 2
`define MD_SEL14 1
`define MD_SEL13 0
`define VSE_RMASK 8'hBF
`define UL_RMASK 8'h7F
`define MD_RMASK 8'hEF
`define REG_RST 8'h00
`define DIV2_LAST 2'h1
`define DIV4_LAST 2'h3
`endif

// File: rtl/vtiming_pkg.sv
// Purpose: Types shared by the vertical timing block
// Assumes: Constants come from vtiming_params.svh
// Notes: All state of the block sits in one packed struct
package vtiming_pkg;
  typedef struct packed {
    logic [7:0] vse;
    logic [7:0] vde;
    logic [7:0] roff;
    logic [7:0] ul;
    logic [7:0] vbs;
    logic [7:0] vbe;
    logic [7:0] mode;
  } regs_t;
  typedef struct packed {
    logic [10:0] vtotal;
    logic [10:0] vsync_start;
    logic [2:0] vde_hi;
    logic [2:0] vbs_hi;
    logic [4:0] max_row;
    logic [19:0] start_addr;
    logic compat;
  } ext_cfg_t;
  typedef struct packed {
    regs_t regs;
    logic [10:0] line;
    logic half;
    logic [4:0] row;
    logic [19:0] lin;
    logic [19:0] base;
    logic [1:0] div;
    logic vdisp;
    logic vsync;
    logic vblank;
    logic irq_pend;
    logic underline;
    logic [19:0] addr;
    logic [7:0] rd_data;
  } state_t;
endpackage : vtiming_pkg

// File: rtl/vtiming.sv
// Purpose: Vertical timing, interrupt and display address generation
// Assumes: Strobes char_tick and line_tick are synchronous one-cycle pulses
// Notes: Address and timing outputs lag their cause by one clock
`include "vtiming_params.svh"
module vtiming (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Indexed register port
  input wire logic [7:0] reg_index,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rd_data,
  // Settings held in registers outside this block
  input wire vtiming_pkg::ext_cfg_t cfg,
  // Horizontal timing strobes
  input wire logic char_tick,
  input wire logic line_tick,
  input wire logic h_display,
  // Timing and memory outputs
  output logic [19:0] disp_addr,
  output logic vsync,
  output logic vblank,
  output logic vdisp,
  output logic underline,
  output logic irq,
  output logic wr_protect
);
  vtiming_pkg::state_t s_r;
  vtiming_pkg::state_t s_nxt;
  logic run;
  logic adv;
  logic [10:0] vde_full;
  logic [10:0] vbs_full;
  logic [10:0] line_new;
  logic [1:0] div_last;
  logic [19:0] step;
  logic [19:0] a;
  logic word_mode;

  assign run = s_r.regs.mode[`MD_HOLD_N];
  assign vde_full = {cfg.vde_hi, s_r.regs.vde};
  assign vbs_full = {cfg.vbs_hi, s_r.regs.vbs};
  assign word_mode = ~s_r.regs.mode[`MD_BYTE];

  always_comb begin
    s_nxt = s_r;
    adv = 1'b0;
    line_new = s_r.line;
    div_last = 2'h0;
    step = 20'h0_0001;
    a = 20'h0_0000;
    case (reg_index)
      `IDX_VSE: s_nxt.rd_data = s_r.regs.vse & `VSE_RMASK;
      `IDX_VDE: s_nxt.rd_data = s_r.regs.vde;
      `IDX_ROFF: s_nxt.rd_data = s_r.regs.roff;
      `IDX_UL: s_nxt.rd_data = s_r.regs.ul & `UL_RMASK;
      `IDX_VBS: s_nxt.rd_data = s_r.regs.vbs;
      `IDX_VBE: s_nxt.rd_data = s_r.regs.vbe;
      `IDX_MODE: s_nxt.rd_data = s_r.regs.mode & `MD_RMASK;
      default: s_nxt.rd_data = 8'h00;
    endcase
    // This block's registers stay writable; the protect bit guards 0-7 and 35 elsewhere
    if (reg_wr) begin
      case (reg_index)
        `IDX_VSE: s_nxt.regs.vse = reg_wdata;
        `IDX_VDE: s_nxt.regs.vde = reg_wdata;
        `IDX_ROFF: s_nxt.regs.roff = reg_wdata;
        `IDX_UL: s_nxt.regs.ul = reg_wdata;
        `IDX_VBS: s_nxt.regs.vbs = reg_wdata;
        `IDX_VBE: s_nxt.regs.vbe = reg_wdata;
        `IDX_MODE: s_nxt.regs.mode = reg_wdata;
        default: ;
      endcase
    end
    if (!s_r.regs.vse[`VSE_ICLR_N]) begin
      s_nxt.irq_pend = 1'b0;
    end
    if (run && line_tick) begin
      adv = ~s_r.regs.mode[`MD_LINE2] | s_r.half;
      s_nxt.half = s_r.regs.mode[`MD_LINE2] & ~s_r.half;
      s_nxt.div = 2'h0;
      // Row scan counts every scan line; only the line counter is halved
      if (s_r.row == cfg.max_row) begin
        s_nxt.row = 5'h00;
        s_nxt.base = s_r.base + {12'h000, s_r.regs.roff};
      end else begin
        s_nxt.row = s_r.row + 5'h01;
      end
      s_nxt.lin = s_nxt.base;
      if (adv) begin
        if (s_r.line == vde_full && !s_r.regs.vse[`VSE_IEN_N] && s_r.regs.vse[`VSE_ICLR_N]
            && !s_r.irq_pend) begin
          s_nxt.irq_pend = 1'b1;
        end
        if (s_r.line == cfg.vtotal) begin
          line_new = 11'h000;
          s_nxt.row = 5'h00;
          s_nxt.base = cfg.start_addr;
          s_nxt.lin = cfg.start_addr;
        end else begin
          line_new = s_r.line + 11'h001;
        end
        s_nxt.line = line_new;
        s_nxt.vdisp = line_new <= vde_full;
        if (line_new == cfg.vsync_start) begin
          s_nxt.vsync = 1'b1;
        end else if (s_r.vsync && line_new[3:0] == s_r.regs.vse[3:0]) begin
          s_nxt.vsync = 1'b0;
        end
        if (line_new == vbs_full + 11'h001) begin
          s_nxt.vblank = 1'b1;
        end else if (s_r.vblank && (cfg.compat ? line_new[4:0] == s_r.regs.vbe[4:0]
                                               : line_new[7:0] == s_r.regs.vbe)) begin
          s_nxt.vblank = 1'b0;
        end
      end
    end else if (run && char_tick && s_r.vdisp && h_display) begin
      // divide the character clock by 1, 2 or 4
      if (s_r.regs.ul[`UL_BY4]) begin
        div_last = `DIV4_LAST;
      end else if (s_r.regs.mode[`MD_LIN2]) begin
        div_last = `DIV2_LAST;
      end
      if (s_r.regs.ul[`UL_BY4] && s_r.regs.mode[`MD_LIN2]) begin
        step = 20'h0_0002;
      end
      if (s_r.div >= div_last) begin
        s_nxt.div = 2'h0;
        s_nxt.lin = s_r.lin + step;
      end else begin
        s_nxt.div = s_r.div + 2'h1;
      end
    end
    s_nxt.underline = s_nxt.row == s_r.regs.ul[4:0] && s_r.regs.ul[4:0] <= cfg.max_row;
    // Address mapping from the updated counter
    if (s_r.regs.ul[`UL_DWORD]) begin
      a = {s_nxt.lin[17:0], 2'h0};
    end else if (word_mode) begin
      a = {s_nxt.lin[18:0], 1'h0};
      a[0] = s_r.regs.mode[`MD_ALT0] ? s_nxt.lin[15] : s_nxt.lin[13];
    end else begin
      a = s_nxt.lin;
    end
    if (s_nxt.vdisp && h_display) begin
      a[13] = s_r.regs.mode[`MD_SEL13] ? (word_mode ? s_nxt.lin[12] : s_nxt.lin[13])
                                       : s_nxt.row[0];
      a[14] = s_r.regs.mode[`MD_SEL14] ? (word_mode ? s_nxt.lin[13] : s_nxt.lin[14])
                                       : s_nxt.row[1];
    end
    s_nxt.addr = a;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rd_data = s_r.rd_data;
  assign disp_addr = s_r.addr;
  assign vsync = s_r.vsync;
  assign vblank = s_r.vblank;
  assign vdisp = s_r.vdisp;
  assign underline = s_r.underline;
  assign irq = s_r.irq_pend;
  assign wr_protect = s_r.regs.vse[`VSE_PROT];

  // Checks
  a_hold_freeze: assert property (@(posedge sys_clk) disable iff (!resetn)
    !run |=> $stable(s_r.line) && $stable(s_r.row) && $stable(s_r.lin))
    else $error("timing moved while held");
  a_irq_disabled: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(irq) |-> !$past(s_r.regs.vse[`VSE_IEN_N]))
    else $error("interrupt raised while disabled");
  a_irq_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    !s_r.regs.vse[`VSE_ICLR_N] |=> !irq)
    else $error("interrupt not cleared");
  a_irq_raise: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && adv && s_r.line == vde_full && !s_r.regs.vse[`VSE_IEN_N]
    && s_r.regs.vse[`VSE_ICLR_N] |=> irq)
    else $error("interrupt missed at display end");
  a_vsync_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(vsync) |-> s_r.line[3:0] == s_r.regs.vse[3:0])
    else $error("sync ended on wrong line");
  a_vsync_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(vsync) |-> s_r.line == cfg.vsync_start)
    else $error("sync started on wrong line");
  a_vblank_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(vblank) |-> s_r.line == vbs_full + 11'h001)
    else $error("blank started on wrong line");
  a_row_offset: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && s_r.row == cfg.max_row && !(adv && s_r.line == cfg.vtotal)
    |=> s_r.base == $past(s_r.base) + {12'h000, $past(s_r.regs.roff)})
    else $error("row offset not added");
  a_underline_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_r.regs.ul[4:0] > cfg.max_row |=> !underline)
    else $error("underline beyond max row");
  a_byte_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    !word_mode && !s_r.regs.ul[`UL_DWORD] && $stable(s_r.regs) |=> disp_addr[0] == s_r.lin[0])
    else $error("byte mode lowest line wrong");
  a_vblank_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(vblank) |-> (cfg.compat ? s_r.line[4:0] == s_r.regs.vbe[4:0] : s_r.line[7:0] == s_r.regs.vbe))
    else $error("blank ended on wrong line");
  a_vsync_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    vsync && !(run && line_tick && adv) |=> vsync)
    else $error("sync dropped between lines");
  a_vblank_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    vblank && !(run && line_tick && adv) |=> vblank)
    else $error("blank dropped between lines");
  a_irq_source: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(irq) |-> $past(s_r.line) == $past(vde_full))
    else $error("interrupt raised away from display end");
  a_irq_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    irq && s_r.regs.vse[`VSE_ICLR_N] |=> irq)
    else $error("pending interrupt dropped without clear");

  // Register port
  a_protect_write: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_wr && reg_index == `IDX_VSE |=> wr_protect == $past(reg_wdata[`VSE_PROT]))
    else $error("protect bit not stored");
  a_read_back: assert property (@(posedge sys_clk) disable iff (!resetn)
    reg_index == `IDX_VDE |=> reg_rd_data == $past(s_r.regs.vde))
    else $error("display end read back wrong");

  // Line and row counters and the vsync, vblank, vdisp and underline outputs they drive
  a_hold_outputs: assert property (@(posedge sys_clk) disable iff (!resetn)
    !run |=> $stable(vsync) && $stable(vblank) && $stable(vdisp))
    else $error("timing outputs moved while held");
  a_vdisp_level: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && adv |=> vdisp == (s_r.line <= $past(vde_full)))
    else $error("display enable on wrong line");
  a_line_halve: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && s_r.regs.mode[`MD_LINE2] && !s_r.half |=> $stable(s_r.line))
    else $error("line counter moved on skipped line");
  a_line_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && !s_r.regs.mode[`MD_LINE2] && s_r.line != cfg.vtotal
    |=> s_r.line == $past(s_r.line) + 11'h001)
    else $error("line counter missed a step");
  a_frame_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && adv && s_r.line == cfg.vtotal
    |=> s_r.line == 11'h000 && s_r.row == 5'h00 && s_r.lin == $past(cfg.start_addr))
    else $error("frame did not restart");
  a_row_wrap: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && s_r.row == cfg.max_row |=> s_r.row == 5'h00)
    else $error("row counter did not wrap");
  a_row_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && s_r.row != cfg.max_row && !(adv && s_r.line == cfg.vtotal)
    |=> s_r.row == $past(s_r.row) + 5'h01)
    else $error("row counter missed a step");
  a_underline_on: assert property (@(posedge sys_clk) disable iff (!resetn)
    underline |-> s_r.row == $past(s_r.regs.ul[4:0]))
    else $error("underline on wrong row");

  // Character clock division
  a_div_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick |=> s_r.div == 2'h0)
    else $error("divider phase not restarted");
  a_char_step: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && char_tick && !line_tick && s_r.vdisp && h_display && !s_r.regs.ul[`UL_BY4]
    && !s_r.regs.mode[`MD_LIN2] |=> s_r.lin == $past(s_r.lin) + 20'h0_0001)
    else $error("linear counter missed a character");
  a_char_half: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && char_tick && !line_tick && s_r.vdisp && h_display && !s_r.regs.ul[`UL_BY4]
    && s_r.regs.mode[`MD_LIN2] && s_r.div == 2'h0 |=> $stable(s_r.lin))
    else $error("linear counter stepped on skipped character");
  a_char_quad: assert property (@(posedge sys_clk) disable iff (!resetn)
    run && char_tick && !line_tick && s_r.vdisp && h_display && s_r.regs.ul[`UL_BY4]
    && s_r.regs.mode[`MD_LIN2] && s_r.div == `DIV4_LAST |=> s_r.lin == $past(s_r.lin) + 20'h0_0002)
    else $error("linear counter did not step twice");

  // Display address mapping
  a_byte_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    !word_mode && !s_r.regs.ul[`UL_DWORD] |=> disp_addr[12:0] == s_r.lin[12:0])
    else $error("byte mode address wrong");
  a_word_lowest: assert property (@(posedge sys_clk) disable iff (!resetn)
    word_mode && !s_r.regs.ul[`UL_DWORD]
    |=> disp_addr[0] == ($past(s_r.regs.mode[`MD_ALT0]) ? s_r.lin[15] : s_r.lin[13]))
    else $error("word mode lowest line wrong");
  a_word_shift: assert property (@(posedge sys_clk) disable iff (!resetn)
    word_mode && !s_r.regs.ul[`UL_DWORD] |=> disp_addr[12:1] == s_r.lin[11:0])
    else $error("word mode address not shifted");
  a_dword_addr: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_r.regs.ul[`UL_DWORD] |=> disp_addr[12:0] == {s_r.lin[10:0], 2'h0})
    else $error("doubleword address not shifted");
  a_sel14_row: assert property (@(posedge sys_clk) disable iff (!resetn)
    !s_r.regs.mode[`MD_SEL14] && s_nxt.vdisp && h_display |=> disp_addr[14] == s_r.row[1])
    else $error("line fourteen not row bit one");
  a_sel14_lin: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_r.regs.mode[`MD_SEL14] && s_nxt.vdisp && h_display
    |=> disp_addr[14] == ($past(word_mode) ? s_r.lin[13] : s_r.lin[14]))
    else $error("line fourteen not counter bit");
  a_sel13_row: assert property (@(posedge sys_clk) disable iff (!resetn)
    !s_r.regs.mode[`MD_SEL13] && s_nxt.vdisp && h_display |=> disp_addr[13] == s_r.row[0])
    else $error("line thirteen not row bit zero");
  a_sel13_lin: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_r.regs.mode[`MD_SEL13] && s_nxt.vdisp && h_display
    |=> disp_addr[13] == ($past(word_mode) ? s_r.lin[12] : s_r.lin[13]))
    else $error("line thirteen not counter bit");

  c_frame_wrap: cover property (@(posedge sys_clk) disable iff (!resetn)
    run && line_tick && adv && s_r.line == cfg.vtotal);
  c_irq: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq));
  c_vsync: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(vsync));
  c_vblank: cover property (@(posedge sys_clk) disable iff (!resetn) $fell(vblank));
  c_row_wrap: cover property (@(posedge sys_clk) disable iff (!resetn)
    line_tick && run && s_r.row == cfg.max_row);
endmodule : vtiming

// File: tb/sync_monitor.sv
// Purpose: Monitor-side model that counts vertical sync pulses
// Assumes: vsync is a registered high-active level
// Notes: Only rising edges count, so a held sync is one frame
module sync_monitor (
  // Clock
  input wire logic sys_clk,
  // Monitor path
  input wire logic vsync,
  output int frames
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_r = 1'b0;
  initial frames = 0;
  always @(posedge sys_clk) begin
    if (vsync && !last_r) frames <= frames + 1;
    last_r <= vsync;
  end
endmodule : sync_monitor

// File: tb/crt_vertical_timing_addressing_tb.sv
// Purpose: Self-checking bench for the vertical timing block
// Assumes: Line counter is tracked here by a small reference model
// Notes: Each awkward case restarts from reset for a known row and line
`include "vtiming_params.svh"
module crt_vertical_timing_addressing_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
  row_t rows[8] = '{'{8'h11, 8'hFF, 8'hBF}, '{8'h12, 8'hA5, 8'hA5}, '{8'h13, 8'h28, 8'h28},
    '{8'h14, 8'hFF, 8'h7F}, '{8'h15, 8'h3C, 8'h3C}, '{8'h16, 8'h5A, 8'h5A},
    '{8'h17, 8'hFF, 8'hEF}, '{8'h20, 8'hFF, 8'h00}};
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_index = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rd_data;
  vtiming_pkg::ext_cfg_t cfg = '{vtotal: 11'h014, vsync_start: 11'h00A, vde_hi: 3'h0, vbs_hi: 3'h0,
    max_row: 5'h03, start_addr: 20'h00000, compat: 1'b0};
  logic char_tick = 1'b0;
  logic line_tick = 1'b0;
  logic h_display = 1'b1;
  logic [19:0] disp_addr;
  logic vsync, vblank, vdisp, underline, irq, wr_protect;
  int failures = 0;
  int checks = 0;
  int frames, f0, n;
  logic [10:0] ln;
  logic vs_m, vb_m, ir_m;
  logic [7:0] vbe_p, msk;
  vtiming u_vtiming (.sys_clk(sys_clk), .resetn(resetn), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .cfg(cfg), .char_tick(char_tick),
    .line_tick(line_tick), .h_display(h_display), .disp_addr(disp_addr), .vsync(vsync),
    .vblank(vblank), .vdisp(vdisp), .underline(underline), .irq(irq), .wr_protect(wr_protect));
  sync_monitor u_sync_monitor (.sys_clk(sys_clk), .vsync(vsync), .frames(frames));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    reg_index <= i;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_index <= i;
    repeat (2) @(posedge sys_clk);
    #1 check(reg_rd_data, exp, "register read");
  endtask : rd
  // Display end 5, blank start 7, so blank rises on line 8
  task automatic restart(input logic [7:0] vse, input logic [7:0] vbe, input logic [7:0] mode,
    input logic cmp);
    @(posedge sys_clk);
    resetn <= 1'b0;
    cfg.compat <= cmp;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    wr(`IDX_VDE, 8'h05);
    wr(`IDX_VBS, 8'h07);
    wr(`IDX_VBE, vbe);
    wr(`IDX_VSE, vse);
    wr(`IDX_MODE, mode);
    ln = 11'h000;
    vs_m = 1'b0;
    vb_m = 1'b0;
    ir_m = 1'b0;
  endtask : restart
  task automatic tick_line();
    @(posedge sys_clk);
    line_tick <= 1'b1;
    @(posedge sys_clk);
    line_tick <= 1'b0;
    #1;
  endtask : tick_line
  // Gaps between char ticks keep each strobe a clean one-cycle pulse
  task automatic addr_case(input logic [7:0] mode, input logic [7:0] ul, input int lines,
    input logic [19:0] exp, input logic exp_ul);
    restart(8'h3D, 8'h0C, mode, 1'b0);
    wr(`IDX_UL, ul);
    wr(`IDX_ROFF, 8'h28);
    repeat (lines) tick_line();
    repeat (6) begin
      @(posedge sys_clk);
      char_tick <= 1'b1;
      @(posedge sys_clk);
      char_tick <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    #1 check(disp_addr, exp, "address");
    check(underline, exp_ul, "underline");
  endtask : addr_case
  initial begin
    restart(8'h1D, 8'h0C, 8'h80, 1'b0);
    check(irq | vsync | vblank, 1'b0, "reset levels");
    foreach (rows[k]) wr(rows[k].idx, rows[k].wd);
    foreach (rows[k]) rd(rows[k].idx, rows[k].rd);
    check(wr_protect, 1'b1, "protect set");
    wr(`IDX_VSE, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 check(wr_protect, 1'b0, "protect clear");
    for (int p = 0; p < 2; p++) begin
      vbe_p = p ? 8'hEC : 8'h0C;
      msk = p ? 8'h1F : 8'hFF;
      restart(8'h1D, vbe_p, 8'h80, p[0]);
      f0 = frames;
      repeat (42) begin
        tick_line();
        ir_m = ir_m | (ln == 11'h005);
        ln = (ln == cfg.vtotal) ? 11'h000 : ln + 11'h001;
        if (ln == cfg.vsync_start) vs_m = 1'b1;
        else if (vs_m && ln[3:0] == 4'hD) vs_m = 1'b0;
        if (ln == 11'h008) vb_m = 1'b1;
        else if (vb_m && (ln[7:0] & msk) == (vbe_p & msk)) vb_m = 1'b0;
        check(vsync, vs_m, "sync");
        check(vblank, vb_m, "blank");
        check(vdisp, ln <= 11'h005, "display");
        check(irq, ir_m, "interrupt");
      end
      check(frames - f0, 2, "frames");
      wr(`IDX_VSE, 8'h0D);
      @(posedge sys_clk);
      #1 check(irq, 1'b0, "interrupt clear");
      wr(`IDX_VSE, 8'h1D);
      repeat (6) tick_line();
      check(irq, 1'b1, "interrupt re-armed");
    end
    restart(8'h3D, 8'h0C, 8'h80, 1'b0);
    repeat (8) tick_line();
    check(irq, 1'b0, "interrupt disabled");
    cfg.vde_hi <= 3'h1;
    restart(8'h3D, 8'h0C, 8'h80, 1'b0);
    repeat (8) tick_line();
    check(vdisp, 1'b1, "display end high bits");
    cfg.vde_hi <= 3'h0;
    restart(8'h1D, 8'h0C, 8'h00, 1'b0);
    repeat (12) tick_line();
    check(irq | vsync, 1'b0, "held");
    restart(8'h1D, 8'h0C, 8'h84, 1'b0);
    n = 0;
    while (irq !== 1'b1) begin
      if (n == 40) begin
        failures++;
        $display("MISMATCH %0t interrupt wait timed out", $time);
        conclude();
      end
      tick_line();
      n++;
    end
    check(n >= 11 && n <= 12, 1'b1, "line halving");
    addr_case(8'hC3, 8'h01, 1, 20'h00006, 1'b1);
    addr_case(8'hCB, 8'h01, 1, 20'h00003, 1'b1);
    addr_case(8'h83, 8'h01, 1, 20'h0000C, 1'b1);
    addr_case(8'hC3, 8'h21, 1, 20'h00001, 1'b1);
    addr_case(8'hCB, 8'h21, 1, 20'h00002, 1'b1);
    addr_case(8'hC3, 8'h41, 1, 20'h00018, 1'b1);
    addr_case(8'hC2, 8'h05, 1, 20'h02006, 1'b0);
    addr_case(8'hC3, 8'h01, 5, 20'h0002E, 1'b1);
    addr_case(8'hC1, 8'h01, 3, 20'h04006, 1'b0);
    cfg.start_addr <= 20'h09000;
    addr_case(8'hA3, 8'h01, 21, 20'h1200D, 1'b0);
    conclude();
  end
endmodule : crt_vertical_timing_addressing_tb
